// ==== hdl/fiber_far_end_fault.sv ====
/*
 Far-end-fault signalling and fiber-mode control for the 100 Mb/s optical
 path: fault idle insertion, fault idle detection, status latching, MII
 gating and the control bits behind them.
 Assumes one code bit per clock on the line side, synchronous inputs and a
 single-cycle register port with read data in the following cycle.
*/
// Notes on behaviour
// - With fault enabled and signal lost, send 84 ones then a zero, repeating.
// - Keep sending the fault pattern until signal detect returns.
// - Three or more received patterns set basic status bit 4 until read.
// - Summary status bit 7 also shows the far-end fault.
// - First received pattern may carry more than 84 leading ones.
// - Receiving the fault pattern never asserts carrier sense.
// - Fault enable clear means the fault pattern is never sent.
// - Detected far-end fault blocks MII receive and transmit; management still works.
// - Auto-negotiation enabled forces the fault function off.
// - Selecting 100 Mb/s fiber turns the fault enable on automatically.
// - Phy control bit 5 selects the fiber interface.
// - Coding control bit 14 is the fault enable.
// - Loopback register bit 11 or 12 bypasses scrambler and descrambler.
// - Coding control bit 15 enables internal signal-detect bias.
// - Fiber mode bypasses scrambling only; other coding stays unchanged.
// - Fiber interface disables the twisted-pair transceiver.
// - Strap low at reset selects fiber mode like the select bit.
`timescale 1ns/1ns
`default_nettype none
module fiber_far_end_fault
   import fiber_fault_pkg::*;
#(
   parameter int unsigned ONES = FAULT_ONES
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic [ADDR_W-1:0] reg_addr,
   input wire logic [DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [DATA_W-1:0] reg_rdata,
   input wire logic optical_signal_detect_in,
   input wire logic optical_rx_in,
   output logic optical_tx_out,
   input wire logic tx_code_in,
   input wire logic fiber_strap_in,
   input wire logic mii_tx_en_in,
   input wire logic mii_rx_dv_in,
   input wire logic mii_crs_in,
   output logic mii_tx_en_out,
   output logic mii_rx_dv_out,
   output logic mii_crs_out,
   output logic fiber_mode_out,
   output logic tp_disable_out,
   output logic scrambler_bypass_out,
   output logic sd_bias_enable_out,
   output logic far_fault_sending_out,
   output logic far_fault_active_out
);

   localparam logic [PAT_W-1:0] PAT_LAST = PAT_W'(ONES);

   typedef struct packed {
      logic an_enable;
      logic far_fault_enable;
      logic sd_bias;
      logic [2:0] loop_mode;
      logic scr_bypass;
      logic scr_bypass_alt;
      logic fiber_select_bit;
      logic strap_done;
      logic fault_latched;
      tx_mode_t tx_mode;
      logic [PAT_W-1:0] pat_cnt;
      logic nrzi_level;
      logic rx_prev;
      logic [DATA_W-1:0] rdata;
      logic mii_tx_en;
      logic mii_rx_dv;
      logic mii_crs;
      logic scr_bypass_out;
      logic fault_out;
   } state_t;

   state_t q;
   state_t d;
   logic det_active;
   logic rx_bit;
   logic fault_on;
   logic block_mii;
   logic code_bit;
   logic [DATA_W-1:0] read_val;

   // ----------------------------------------------------------------
   // Fault pattern detector
   // ----------------------------------------------------------------
   assign rx_bit = optical_rx_in ^ q.rx_prev;

   fault_pattern_detect #(
      .ONES(ONES),
      .MIN_PATTERNS(FAULT_MIN_PATTERNS)
   ) u_detect (
      .clock(clock),
      .rst_b(rst_b),
      .bit_in(rx_bit),
      .fault_active(det_active)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      fault_on = q.far_fault_enable & q.fiber_select_bit & ~q.an_enable;
      block_mii = fault_on & det_active;

      // Register read view
      read_val = READ_ZERO;
      unique case (reg_addr)
         ADDR_BASIC_CTRL: read_val[BIT_AN_ENABLE] = q.an_enable;
         ADDR_BASIC_STATUS: read_val[BIT_REMOTE_FAULT] = q.fault_latched;
         ADDR_SUMMARY_STATUS: read_val[BIT_SUMMARY_FAULT] = block_mii;
         ADDR_CODING_CTRL: begin
            read_val[BIT_FAULT_ENABLE] = q.far_fault_enable;
            read_val[BIT_SD_BIAS] = q.sd_bias;
         end
         ADDR_LOOPBACK: begin
            read_val[LOOP_MODE_MSB:LOOP_MODE_LSB] = q.loop_mode;
            read_val[BIT_SCR_BYPASS] = q.scr_bypass;
            read_val[BIT_SCR_BYPASS_ALT] = q.scr_bypass_alt;
         end
         ADDR_PHY_CTRL: read_val[BIT_FIBER_SELECT] = q.fiber_select_bit;
         default: read_val = READ_ZERO;
      endcase
      d.rdata = reg_rd ? read_val : READ_ZERO;

      // Register writes
      if (reg_wr) begin
         unique case (reg_addr)
            ADDR_BASIC_CTRL: d.an_enable = reg_wdata[BIT_AN_ENABLE];
            ADDR_CODING_CTRL: begin
               d.far_fault_enable = reg_wdata[BIT_FAULT_ENABLE];
               d.sd_bias = reg_wdata[BIT_SD_BIAS];
            end
            ADDR_LOOPBACK: begin
               d.loop_mode = reg_wdata[LOOP_MODE_MSB:LOOP_MODE_LSB];
               d.scr_bypass = reg_wdata[BIT_SCR_BYPASS];
               d.scr_bypass_alt = reg_wdata[BIT_SCR_BYPASS_ALT];
            end
            ADDR_PHY_CTRL: begin
               d.fiber_select_bit = reg_wdata[BIT_FIBER_SELECT];
               if (reg_wdata[BIT_FIBER_SELECT] && !q.fiber_select_bit) begin
                  d.far_fault_enable = 1'b1;
               end
            end
            default: d.rdata = d.rdata;
         endcase
      end

      // Strap caught once after reset release
      if (!q.strap_done) begin
         d.strap_done = 1'b1;
         if (!fiber_strap_in) begin
            d.fiber_select_bit = 1'b1;
            d.far_fault_enable = 1'b1;
         end
      end

      // Latched status: set wins over clear-on-read
      if (reg_rd && reg_addr == ADDR_BASIC_STATUS) begin
         d.fault_latched = 1'b0;
      end
      if (block_mii) begin
         d.fault_latched = 1'b1;
      end

      // Transmit fault idle
      unique case (q.tx_mode)
         TX_NORMAL: begin
            d.pat_cnt = '0;
            if (fault_on && !optical_signal_detect_in) begin
               d.tx_mode = TX_FAULT;
            end
         end
         TX_FAULT: begin
            d.pat_cnt = (q.pat_cnt == PAT_LAST) ? '0 : q.pat_cnt + 1'b1;
            if (!fault_on || optical_signal_detect_in) begin
               d.tx_mode = TX_NORMAL;
            end
         end
      endcase
      if (q.tx_mode == TX_FAULT) begin
         code_bit = (q.pat_cnt != PAT_LAST);
      end else begin
         code_bit = tx_code_in;
      end
      d.nrzi_level = q.nrzi_level ^ code_bit;
      d.rx_prev = optical_rx_in;

      // MII gating and config outputs
      d.mii_tx_en = mii_tx_en_in & ~block_mii;
      d.mii_rx_dv = mii_rx_dv_in & ~block_mii;
      d.mii_crs = mii_crs_in & ~block_mii;
      d.scr_bypass_out = d.fiber_select_bit | d.scr_bypass | d.scr_bypass_alt;
      d.fault_out = block_mii;
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
         q.an_enable <= RESET_AN_ENABLE;
         q.loop_mode <= RESET_LOOP_MODE;
         q.tx_mode <= TX_NORMAL;
      end else begin
         q <= d;
      end
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign reg_rdata = q.rdata;
   assign optical_tx_out = q.nrzi_level;
   assign mii_tx_en_out = q.mii_tx_en;
   assign mii_rx_dv_out = q.mii_rx_dv;
   assign mii_crs_out = q.mii_crs;
   assign fiber_mode_out = q.fiber_select_bit;
   assign tp_disable_out = q.fiber_select_bit;
   assign scrambler_bypass_out = q.scr_bypass_out;
   assign sd_bias_enable_out = q.sd_bias;
   assign far_fault_sending_out = (q.tx_mode == TX_FAULT);
   assign far_fault_active_out = q.fault_out;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence seq_status_read;
      reg_rd && reg_addr == ADDR_BASIC_STATUS && !block_mii;
   endsequence

   sequence seq_fault_start;
      fault_on && !optical_signal_detect_in && q.tx_mode == TX_NORMAL;
   endsequence

   a_fault_start_send: assert property (@(posedge clock) disable iff (!rst_b)
      seq_fault_start |=> (q.tx_mode == TX_FAULT && q.pat_cnt == '0))
      else $error("Fault pattern did not start");

   a_pattern_zero_bit: assert property (@(posedge clock) disable iff (!rst_b)
      (q.tx_mode == TX_FAULT && q.pat_cnt == PAT_LAST) |=> $stable(optical_tx_out))
      else $error("Fault pattern zero bit not sent");

   a_pattern_one_bit: assert property (@(posedge clock) disable iff (!rst_b)
      (q.tx_mode == TX_FAULT && q.pat_cnt != PAT_LAST) |=> $changed(optical_tx_out))
      else $error("Fault pattern one bit not sent");

   a_sd_return_idle: assert property (@(posedge clock) disable iff (!rst_b)
      (q.tx_mode == TX_FAULT && optical_signal_detect_in) |=> q.tx_mode == TX_NORMAL)
      else $error("Fault pattern kept after signal detect");

   a_disabled_no_send: assert property (@(posedge clock) disable iff (!rst_b)
      (!q.far_fault_enable || q.an_enable) |=> q.tx_mode == TX_NORMAL)
      else $error("Fault pattern sent while disabled");

   a_status_read_clear: assert property (@(posedge clock) disable iff (!rst_b)
      seq_status_read ##1 1'b1 |-> !q.fault_latched)
      else $error("Remote fault bit not cleared by read");

   a_status_hold: assert property (@(posedge clock) disable iff (!rst_b)
      (q.fault_latched && !(reg_rd && reg_addr == ADDR_BASIC_STATUS)) |=> q.fault_latched)
      else $error("Remote fault bit dropped before read");

   a_mii_blocked: assert property (@(posedge clock) disable iff (!rst_b)
      block_mii |=> (!mii_tx_en_out && !mii_rx_dv_out && !mii_crs_out && far_fault_active_out))
      else $error("MII activity passed during far-end fault");

   a_summary_bit: assert property (@(posedge clock) disable iff (!rst_b)
      (reg_rd && reg_addr == ADDR_SUMMARY_STATUS) |=> reg_rdata[BIT_SUMMARY_FAULT] == $past(block_mii))
      else $error("Summary fault bit wrong");

   a_fiber_auto_enable: assert property (@(posedge clock) disable iff (!rst_b)
      $rose(q.fiber_select_bit) |-> q.far_fault_enable)
      else $error("Fiber select did not enable fault function");

   a_strap_selects: assert property (@(posedge clock) disable iff (!rst_b)
      ($rose(q.strap_done) && !$past(fiber_strap_in)) |-> fiber_mode_out && q.far_fault_enable)
      else $error("Strap did not select fiber mode");

   a_select_write: assert property (@(posedge clock) disable iff (!rst_b)
      (reg_wr && reg_addr == ADDR_PHY_CTRL && q.strap_done)
         |=> fiber_mode_out == $past(reg_wdata[BIT_FIBER_SELECT]))
      else $error("Fiber select bit not written");

   a_enable_write: assert property (@(posedge clock) disable iff (!rst_b)
      (reg_wr && reg_addr == ADDR_CODING_CTRL && q.strap_done)
         |=> q.far_fault_enable == $past(reg_wdata[BIT_FAULT_ENABLE]))
      else $error("Fault enable bit not written");

   a_mii_release: assert property (@(posedge clock) disable iff (!rst_b)
      !block_mii
         |=> (mii_tx_en_out == $past(mii_tx_en_in) && mii_rx_dv_out == $past(mii_rx_dv_in)))
      else $error("MII activity held without far-end fault");

   a_crs_source: assert property (@(posedge clock) disable iff (!rst_b)
      mii_crs_out |-> $past(mii_crs_in) && !$past(block_mii))
      else $error("Carrier sense raised without upstream carrier");

endmodule : fiber_far_end_fault
`default_nettype wire

// ==== hdl/fiber_fault_pkg.sv ====
/*
 Constants shared by the fiber far-end-fault block: register addresses,
 field positions, reset values, pattern lengths and state encodings.
 Assumes a 16-bit management register space with 5-bit addresses.
*/
package fiber_fault_pkg;

   // ----------------------------------------------------------------
   // Register bus
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 16;

   localparam logic [ADDR_W-1:0] ADDR_BASIC_CTRL = 5'h00;
   localparam logic [ADDR_W-1:0] ADDR_BASIC_STATUS = 5'h01;
   localparam logic [ADDR_W-1:0] ADDR_SUMMARY_STATUS = 5'h10;
   localparam logic [ADDR_W-1:0] ADDR_CODING_CTRL = 5'h16;
   localparam logic [ADDR_W-1:0] ADDR_LOOPBACK = 5'h17;
   localparam logic [ADDR_W-1:0] ADDR_PHY_CTRL = 5'h19;

   // ----------------------------------------------------------------
   // Field positions
   // ----------------------------------------------------------------
   localparam int unsigned BIT_AN_ENABLE = 12;
   localparam int unsigned BIT_REMOTE_FAULT = 4;
   localparam int unsigned BIT_SUMMARY_FAULT = 7;
   localparam int unsigned BIT_FAULT_ENABLE = 14;
   localparam int unsigned BIT_SD_BIAS = 15;
   localparam int unsigned BIT_SCR_BYPASS = 11;
   localparam int unsigned BIT_SCR_BYPASS_ALT = 12;
   localparam int unsigned BIT_FIBER_SELECT = 5;
   localparam int unsigned LOOP_MODE_LSB = 7;
   localparam int unsigned LOOP_MODE_MSB = 9;

   // ----------------------------------------------------------------
   // Reset values
   // ----------------------------------------------------------------
   localparam logic RESET_AN_ENABLE = 1'b1;
   localparam logic [2:0] RESET_LOOP_MODE = 3'h0;
   localparam logic [DATA_W-1:0] READ_ZERO = 16'h0000;

   // ----------------------------------------------------------------
   // Fault idle pattern
   // ----------------------------------------------------------------
   localparam int unsigned FAULT_ONES = 84;
   localparam int unsigned FAULT_MIN_PATTERNS = 3;
   localparam int unsigned RUN_W = 8;
   localparam int unsigned PAT_W = 7;

   typedef enum logic {
      TX_NORMAL,
      TX_FAULT
   } tx_mode_t;

endpackage : fiber_fault_pkg

// ==== hdl/fault_pattern_detect.sv ====
/*
 Receive-side detector for the repeating fault idle pattern.
 Assumes one decoded code bit per clock, already out of NRZI.
*/
`timescale 1ns/1ns
`default_nettype none
module fault_pattern_detect
   import fiber_fault_pkg::*;
#(
   parameter int unsigned ONES = FAULT_ONES,
   parameter int unsigned MIN_PATTERNS = FAULT_MIN_PATTERNS
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic bit_in,
   output logic fault_active
);

   localparam logic [RUN_W-1:0] RUN_ONES = RUN_W'(ONES);
   localparam logic [RUN_W-1:0] RUN_MAX = RUN_W'(2 * (ONES + 1));
   localparam logic [1:0] CNT_MIN = 2'(MIN_PATTERNS);

   typedef struct packed {
      logic [RUN_W-1:0] run;
      logic [1:0] count;
      logic active;
   } det_state_t;

   det_state_t q;
   det_state_t d;

   // ----------------------------------------------------------------
   // Pattern counting
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      if (bit_in) begin
         if (q.run != RUN_MAX) begin
            d.run = q.run + 1'b1;
         end
         if (d.run == RUN_MAX) begin
            d.count = 2'h0;
            d.active = 1'b0;
         end
      end else begin
         d.run = '0;
         if (q.run >= RUN_ONES) begin
            if (q.run == RUN_ONES && q.count != 2'h0) begin
               d.count = (q.count == CNT_MIN) ? q.count : q.count + 1'b1;
            end else begin
               d.count = 2'h1;
            end
            d.active = q.active | (d.count >= CNT_MIN);
         end else begin
            d.count = 2'h0;
            d.active = 1'b0;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign fault_active = q.active;

   a_long_first_ok: assert property (@(posedge clock) disable iff (!rst_b)
      (!bit_in && q.run > RUN_ONES && q.run < RUN_MAX) |=> (q.count == 2'h1))
      else $error("Longer first pattern not counted");

   a_data_clears: assert property (@(posedge clock) disable iff (!rst_b)
      (!bit_in && q.run < RUN_ONES) |=> (!q.active && q.count == 2'h0))
      else $error("Data zero did not restart pattern count");

endmodule : fault_pattern_detect
`default_nettype wire

// ==== test/optical_partner.sv ====
/*
 Far-side model: optical transceiver with a remote station behind it.
 Assumes the bench calls its tasks right after a rising clock edge.
*/
`timescale 1ns/1ns
`default_nettype none
module optical_partner #(
   parameter int unsigned ONES = 8
) (
   input wire logic clock,
   input wire logic rst_b,
   output logic signal_detect,
   output logic rx_line
);
   bit code_q[$];
   logic code;

   initial signal_detect = 1'b1;

   // --------------------
   // Line encoder
   // --------------------
   // Empty queue sends plain idle; without signal the line toggles every cycle
   always @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         rx_line <= 1'b0;
      end else begin
         code = (code_q.size() > 0) ? code_q.pop_front() : 1'b1;
         rx_line <= rx_line ^ (code | ~signal_detect);
      end
   end

   // --------------------
   // Control tasks
   // --------------------
   task automatic set_detect(input logic v);
      signal_detect <= v;
   endtask : set_detect

   // Remote fault idle: a run of ones closed by one zero
   task automatic push_run(input int unsigned n);
      for (int unsigned i = 0; i < n; i++) begin
         code_q.push_back(1'b1);
      end
      code_q.push_back(1'b0);
   endtask : push_run

   task automatic wait_empty();
      while (code_q.size() > 0) begin
         @(posedge clock);
      end
   endtask : wait_empty
endmodule : optical_partner
`default_nettype wire

// ==== test/test_fiber_far_end_fault.sv ====
/*
 Self-checking bench for the fiber far-end-fault block.
 Assumes the package and the optical partner model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none
module test_fiber_far_end_fault
   import fiber_fault_pkg::*;
;
   localparam int unsigned ONES = 8;
   localparam int PER = ONES + 1;
   localparam int LIMIT = 20000;

   logic clock = 1'b0;
   logic rst_b = 1'b0;
   logic [ADDR_W-1:0] reg_addr = '0;
   logic [DATA_W-1:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [DATA_W-1:0] reg_rdata;
   logic sd, rx, tx;
   logic tx_code_in;
   logic strap = 1'b1;
   logic tx_en_in, rx_dv_in, crs_in, mii_on = 1'b0;
   logic tx_en_out, rx_dv_out, crs_out, fiber_mode, tp_disable;
   logic scr_bypass, sd_bias, sending, active;
   logic rd_seen = 1'b0, rnd_en = 1'b0, blk_exp = 1'b0;
   logic [DATA_W-1:0] exp_q[$];
   logic [ADDR_W-1:0] ua;
   int mismatches = 0, checks_done = 0, cycles = 0, z;

   always #5 clock = ~clock;

   fiber_far_end_fault #(.ONES(ONES)) DUT (
      .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .optical_signal_detect_in(sd), .optical_rx_in(rx), .optical_tx_out(tx),
      .tx_code_in(tx_code_in), .fiber_strap_in(strap), .mii_tx_en_in(tx_en_in),
      .mii_rx_dv_in(rx_dv_in), .mii_crs_in(crs_in), .mii_tx_en_out(tx_en_out),
      .mii_rx_dv_out(rx_dv_out), .mii_crs_out(crs_out), .fiber_mode_out(fiber_mode),
      .tp_disable_out(tp_disable), .scrambler_bypass_out(scr_bypass),
      .sd_bias_enable_out(sd_bias), .far_fault_sending_out(sending),
      .far_fault_active_out(active)
   );

   optical_partner #(.ONES(ONES)) partner (
      .clock(clock), .rst_b(rst_b), .signal_detect(sd), .rx_line(rx)
   );

   // --------------------
   // Checking and closing
   // --------------------
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   // Watcher: read data and gated MII outputs
   always @(posedge clock) begin
      rd_seen <= reg_rd;
      if (rd_seen) begin
         check(reg_rdata, exp_q.pop_front());
      end
      if (blk_exp) begin
         check({13'h0, tx_en_out, rx_dv_out, crs_out}, 16'h0000);
      end
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         mismatches++;
         close_out();
      end
   end

   // Random line codes and MII activity
   always @(posedge clock) begin
      if (rnd_en) begin
         tx_code_in <= 1'($urandom);
         tx_en_in <= 1'($urandom);
         rx_dv_in <= 1'($urandom);
         crs_in <= 1'($urandom);
      end else begin
         tx_code_in <= 1'b1;
         tx_en_in <= mii_on;
         rx_dv_in <= mii_on;
         crs_in <= 1'b0;
      end
   end

   // --------------------
   // Drivers
   // --------------------
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask : tick

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      exp_q.push_back(e);
      @(posedge clock);
      reg_rd <= 1'b0;
   endtask : rd

   // Counts decoded zeros on the transmit line, checking their spacing
   task automatic watch_tx(input int n, output int zeros);
      int last = -1;
      logic prev;
      zeros = 0;
      prev = tx;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         if (tx == prev) begin
            if (last >= 0) check(16'(i - last), 16'(PER));
            last = i;
            zeros++;
         end
         prev = tx;
      end
   endtask : watch_tx

   // --------------------
   // Scenarios
   // --------------------
   initial begin
      void'($urandom(32'h7aff3fa1));
      tick(20);
      rst_b <= 1'b1;
      // Reset values, unmapped address
      rd(ADDR_BASIC_CTRL, 16'h1000);
      rd(ADDR_BASIC_STATUS, 16'h0000);
      rd(ADDR_CODING_CTRL, 16'h0000);
      ua = ADDR_W'(2 + $urandom % 14);
      wr(ua, 16'($urandom));
      rd(ua, 16'h0000);
      // Fiber without fault signalling
      wr(ADDR_LOOPBACK, 16'h1180);
      wr(ADDR_BASIC_CTRL, 16'h0000);
      tick(2);
      check(16'(scr_bypass), 16'h0001);
      rd(ADDR_LOOPBACK, 16'h1180);
      wr(ADDR_LOOPBACK, 16'h0800);
      tick(2);
      check(16'(scr_bypass), 16'h0001);
      wr(ADDR_LOOPBACK, 16'h0000);
      tick(2);
      check(16'(scr_bypass), 16'h0000);
      wr(ADDR_PHY_CTRL, 16'h0020);
      rd(ADDR_CODING_CTRL, 16'h4000);
      wr(ADDR_CODING_CTRL, 16'h0000);
      tick(2);
      check({13'h0, fiber_mode, tp_disable, scr_bypass}, 16'h0007);
      partner.set_detect(1'b0);
      tick(3);
      watch_tx(3 * PER, z);
      check(16'(z), 16'h0000);
      check(16'(sending), 16'h0000);
      // Fault idle transmit
      wr(ADDR_CODING_CTRL, 16'hc000);
      rnd_en <= 1'b1;
      tick(3);
      check({14'h0, sd_bias, sending}, 16'h0003);
      watch_tx(4 * PER, z);
      check(16'(z), 16'h0004);
      partner.set_detect(1'b1);
      tick(3);
      check(16'(sending), 16'h0000);
      rnd_en <= 1'b0;
      wr(ADDR_BASIC_CTRL, 16'h1000);
      partner.set_detect(1'b0);
      tick(4);
      check(16'(sending), 16'h0000);
      partner.set_detect(1'b1);
      wr(ADDR_BASIC_CTRL, 16'h0000);
      // Fault idle receive
      mii_on <= 1'b1;
      tick(3);
      check({14'h0, tx_en_out, rx_dv_out}, 16'h0003);
      partner.push_run(3 * ONES);
      partner.push_run(ONES);
      partner.push_run(3);
      partner.push_run(ONES);
      partner.push_run(ONES);
      partner.wait_empty();
      tick(4);
      check({14'h0, active, crs_out}, 16'h0000);
      repeat (6) partner.push_run(ONES);
      tick(3 * PER + 4);
      check({14'h0, active, crs_out}, 16'h0002);
      blk_exp <= 1'b1;
      rnd_en <= 1'b1;
      rd(ADDR_SUMMARY_STATUS, 16'h0080);
      tick(15);
      rnd_en <= 1'b0;
      tick(1);
      blk_exp <= 1'b0;
      partner.wait_empty();
      tick(2 * PER + 6);
      check({14'h0, active, tx_en_out}, 16'h0001);
      rd(ADDR_BASIC_STATUS, 16'h0010);
      rd(ADDR_BASIC_STATUS, 16'h0000);
      // Strap selects fiber at reset
      rst_b <= 1'b0;
      strap <= 1'b0;
      tick(2);
      rst_b <= 1'b1;
      tick(3);
      check(16'(fiber_mode), 16'h0001);
      rd(ADDR_PHY_CTRL, 16'h0020);
      rd(ADDR_CODING_CTRL, 16'h4000);
      rd(ADDR_BASIC_STATUS, 16'h0000);
      tick(3);
      close_out();
   end
endmodule : test_fiber_far_end_fault
`default_nettype wire
